// >>> include/sht_pkg.sv
// Constants, register map and state types for the event enable and tuning block.
// Assumes a 32-bit Avalon-MM slave port with a word address and one clock.
package sht_pkg;

	// Word indexes of the registers; byte address is four times the index.
	localparam logic [2:0] IDX_FLAGS  = 3'h0;
	localparam logic [2:0] IDX_MASK   = 3'h1;
	localparam logic [2:0] IDX_ENABLE = 3'h2;
	localparam logic [2:0] IDX_CTRL2  = 3'h3;
	localparam logic [2:0] IDX_INJECT = 3'h4;

	// Event bits that exist in the flag, mask, enable and inject registers.
	localparam logic [31:0] EVT_VALID = 32'h017f7137;
	// Event bits that count as errors for the summary bit.
	localparam logic [31:0] EVT_ERRS  = 32'h017f0000;
	// Position of the read-only summary error bit in the flag register.
	localparam int          ERR_SUM_BIT = 15;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;

	// Field positions of host_control_two.
	localparam int TUNED_BIT  = 23;
	localparam int ALIGNMENT_RUNNING_BIT = 22;
	localparam int SPEED_LSB  = 16;
	localparam int AUTO_STOP_BIT = 7;

	// Speed mode codes.
	localparam logic [2:0] SPEED_SDR12  = 3'h0;
	localparam logic [2:0] SPEED_SDR25  = 3'h1;
	localparam logic [2:0] SPEED_SDR50  = 3'h2;
	localparam logic [2:0] SPEED_SDR104 = 3'h3;
	localparam logic [2:0] SPEED_DDR50  = 3'h4;

	// Auto-command status as reported by the command engine.
	typedef struct packed {
		logic auto_stop_fault;
		logic auto_index_fault;
		logic auto_endbit_fault;
		logic auto_crc_fault;
		logic auto_timeout_fault;
		logic auto_skipped;
	} sht_auto_t;

	// Tuning sequence states.
	typedef enum logic [0:0] {TUNE_IDLE, TUNE_BUSY} sht_tune_t;

	// Whole state of the block.
	typedef struct packed {
		logic [31:0] flags_reg;
		logic [31:0] mask_reg;
		logic [31:0] enable_reg;
		logic [31:0] inject_reg;
		logic        tuned_reg;
		sht_tune_t   tune_reg;
		logic [2:0]  speed_reg;
		sht_auto_t   auto_reg;
		logic        wait_reg;
		logic [31:0] rdata_reg;
		logic        irq_reg;
	} sht_state_t;

endpackage

// >>> logic/sht_event_ctrl.sv
// Event flags, event enable, event injection and speed/tuning control.
// Assumes an Avalon-MM master that holds each request until waitrequest is low.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module sht_event_ctrl
	import sht_pkg::*;
(
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Avalon-MM slave port, word addressed.
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Event pulses from the card engines, one bit per flag position.
	input  wire logic [31:0] event_in,
	// Auto-command status from the command engine.
	input  wire sht_auto_t   auto_status,
	// Tuning engine reports completion or that no tuning is needed.
	input  wire logic        tune_done,
	// Control toward the card side and the processor.
	output logic             cpu_irq_out,
	output logic             tuned_clk_sel,
	output logic             alignment_running,
	output logic [2:0]       bus_speed_select
);

	////////////////////////////////////////////////////////////////////////
	// State and bus decode.

	// Registered state and its next value.
	sht_state_t st_reg;
	sht_state_t st_next;

	// Request present on the bus.
	logic req;
	// Write committed in this cycle.
	logic wr_go;
	// Byte lanes of the write data merged over a register.
	logic [31:0] be_mask;
	// Flag register as software reads it, summary bit included.
	logic [31:0] flags_view;
	// Control register as software reads it.
	logic [31:0] ctrl2_view;
	// Events injected by this write.
	logic [31:0] inj_pulse;
	// Events that may set flags this cycle.
	logic [31:0] set_vec;
	// Flags cleared by this write.
	logic [31:0] clr_vec;

	assign req = avs_read | avs_write;
	assign wr_go = avs_write & ~st_reg.wait_reg;

	// Byte enables widened to one bit per data bit.
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_lane
			assign be_mask[g*8 +: 8] = {8{avs_byteenable[g]}};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read views.

	// Summary error bit is derived, never stored or written.
	always_comb
	begin
		flags_view = st_reg.flags_reg;
		flags_view[ERR_SUM_BIT] = |(st_reg.flags_reg & EVT_ERRS);
	end

	// Control register image; unused bits read as zero.
	always_comb
	begin
		ctrl2_view = ZERO_WORD;
		ctrl2_view[TUNED_BIT] = st_reg.tuned_reg;
		ctrl2_view[ALIGNMENT_RUNNING_BIT] = (st_reg.tune_reg == TUNE_BUSY);
		ctrl2_view[SPEED_LSB +: 3] = st_reg.speed_reg;
		ctrl2_view[AUTO_STOP_BIT] = st_reg.auto_reg.auto_stop_fault;
		ctrl2_view[4:0] = st_reg.auto_reg[4:0];
	end

	////////////////////////////////////////////////////////////////////////
	// Event set and clear terms.

	// Injection fires only on the committing write edge.
	always_comb
	begin
		inj_pulse = ZERO_WORD;
		clr_vec = ZERO_WORD;
		if (wr_go && avs_address == IDX_INJECT)
		begin
			// Ones fake events, zeros do nothing.
			inj_pulse = avs_writedata & be_mask & EVT_VALID;
		end
		if (wr_go && avs_address == IDX_FLAGS)
		begin
			// Software clears a flag by writing one to it.
			clr_vec = avs_writedata & be_mask & EVT_VALID;
		end
		// Real and injected events pass the same mask.
		set_vec = (event_in | inj_pulse) & st_reg.mask_reg & EVT_VALID;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// One process computes every next value of the state.
	always_comb
	begin
		st_next = st_reg;
		// Wait is high by default and drops for one cycle per request.
		st_next.wait_reg = ~(req & st_reg.wait_reg);
		// Read data is taken while waiting, so it stands in the answer cycle.
		if (avs_read && st_reg.wait_reg)
		begin
			case (avs_address)
				IDX_FLAGS:  st_next.rdata_reg = flags_view;
				IDX_MASK:   st_next.rdata_reg = st_reg.mask_reg;
				IDX_ENABLE: st_next.rdata_reg = st_reg.enable_reg;
				IDX_CTRL2:  st_next.rdata_reg = ctrl2_view;
				IDX_INJECT: st_next.rdata_reg = st_reg.inject_reg;
				default:    st_next.rdata_reg = ZERO_WORD;
			endcase
		end
		// A set arriving with its clear wins.
		st_next.flags_reg = (st_reg.flags_reg & ~clr_vec) | set_vec;
		// Register writes keep only documented bits.
		if (wr_go)
		begin
			case (avs_address)
				IDX_MASK:
				begin
					st_next.mask_reg = ((st_reg.mask_reg & ~be_mask)
						| (avs_writedata & be_mask)) & EVT_VALID;
				end
				IDX_ENABLE:
				begin
					st_next.enable_reg = ((st_reg.enable_reg & ~be_mask)
						| (avs_writedata & be_mask)) & EVT_VALID;
				end
				IDX_INJECT:
				begin
					st_next.inject_reg = ((st_reg.inject_reg & ~be_mask)
						| (avs_writedata & be_mask)) & EVT_VALID;
				end
				IDX_CTRL2:
				begin
					if (avs_byteenable[2])
					begin
						st_next.tuned_reg = avs_writedata[TUNED_BIT];
						st_next.speed_reg = avs_writedata[SPEED_LSB +: 3];
					end
				end
				default:
				begin
					st_next.rdata_reg = st_next.rdata_reg;
				end
			endcase
		end
		// Tuning: a start counts only when idle and a completion only when busy.
		case (st_reg.tune_reg)
			TUNE_IDLE:
			begin
				if (wr_go && avs_address == IDX_CTRL2 && avs_byteenable[2]
					&& avs_writedata[ALIGNMENT_RUNNING_BIT])
				begin
					st_next.tune_reg = TUNE_BUSY;
				end
			end
			TUNE_BUSY:
			begin
				if (tune_done)
				begin
					st_next.tune_reg = TUNE_IDLE;
				end
			end
			default:
			begin
				st_next.tune_reg = TUNE_IDLE;
			end
		endcase
		// Auto-command status is sampled every cycle.
		st_next.auto_reg = auto_status;
		// Interrupt is every flag ANDed with its enable, ORed together.
		st_next.irq_reg = |(st_reg.flags_reg & st_reg.enable_reg);
		if (rst)
		begin
			st_next = '0;
			st_next.wait_reg = 1'b1;
			st_next.tune_reg = TUNE_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	// The whole state is registered on the clock.
	always_ff @(posedge ref_clk)
	begin
		st_reg <= st_next;
	end

	// Outputs come straight from state flip-flops.
	assign avs_readdata = st_reg.rdata_reg;
	assign avs_waitrequest = st_reg.wait_reg;
	assign cpu_irq_out = st_reg.irq_reg;
	assign tuned_clk_sel = st_reg.tuned_reg;
	assign alignment_running = (st_reg.tune_reg == TUNE_BUSY);
	assign bus_speed_select = st_reg.speed_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Helper: enabled flags of the previous cycle.
	logic [31:0] live_prev;
	always_ff @(posedge ref_clk)
	begin
		live_prev <= st_reg.flags_reg & st_reg.enable_reg;
	end

	irq_follows_a: assert property (##1 cpu_irq_out == |live_prev)
		else $error("interrupt does not follow flags and enables");

	irq_gated_a: assert property (st_reg.enable_reg == ZERO_WORD [*2] |-> !cpu_irq_out)
		else $error("interrupt raised with all enables clear");

	acmd_gate_a: assert property (st_reg.flags_reg[24] && st_reg.enable_reg[24]
		|=> cpu_irq_out)
		else $error("enabled auto-command error gives no interrupt");

	mask_blocks_a: assert property (!st_reg.mask_reg[20] && !st_reg.flags_reg[20]
		|=> !st_reg.flags_reg[20])
		else $error("masked event set its flag");

	inject_sets_a: assert property (wr_go && avs_address == IDX_INJECT
		&& avs_writedata[0] && avs_byteenable[0] && st_reg.mask_reg[0]
		|=> st_reg.flags_reg[0])
		else $error("inject did not set flag");

	set_wins_a: assert property (event_in[16] && st_reg.mask_reg[16]
		&& clr_vec[16] |=> st_reg.flags_reg[16])
		else $error("clear beat a simultaneous event");

	reserved_zero_a: assert property ((st_reg.enable_reg & ~EVT_VALID) == ZERO_WORD
		&& (st_reg.inject_reg & ~EVT_VALID) == ZERO_WORD)
		else $error("reserved bits stored");

	tune_start_a: assert property (st_reg.tune_reg == TUNE_IDLE && wr_go
		&& avs_address == IDX_CTRL2 && avs_byteenable[2] && avs_writedata[ALIGNMENT_RUNNING_BIT]
		|=> alignment_running)
		else $error("tuning did not start");

	tune_end_a: assert property (alignment_running && tune_done |=> !alignment_running)
		else $error("tuning did not end on done");

	speed_write_a: assert property (wr_go && avs_address == IDX_CTRL2
		&& avs_byteenable[2] |=> bus_speed_select == $past(avs_writedata[18:16]))
		else $error("speed select not written");

	answer_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("answer not exactly one cycle after request");

	summary_a: assert property (avs_read && avs_address == IDX_FLAGS && avs_waitrequest
		|=> avs_readdata[ERR_SUM_BIT] == |($past(st_reg.flags_reg) & EVT_ERRS))
		else $error("summary error bit wrong");

	reset_zero_a: assert property (disable iff (1'b0) $past(rst) |-> st_reg.enable_reg == ZERO_WORD
		&& st_reg.inject_reg == ZERO_WORD && bus_speed_select == SPEED_SDR12
		&& !tuned_clk_sel && !alignment_running)
		else $error("control not zero after reset");

	irq_seen_c: cover property (!cpu_irq_out ##1 cpu_irq_out);
	inject_seen_c: cover property (wr_go && avs_address == IDX_INJECT);
	tune_seen_c: cover property (alignment_running ##1 !alignment_running);
	ddr_seen_c: cover property (bus_speed_select == SPEED_DDR50);

endmodule

// >>> verification/sht_card_model.sv
// Card-side engine model: event pulses and the tuning engine.
// Assumes one clock; the bench calls pulse and sets tune_lat.
`timescale 1ns/1ps
module sht_card_model
	import sht_pkg::*;
(
	// Clock and tuning state from the block.
	input  wire logic        ref_clk,
	input  wire logic        alignment_running,
	// Event pulses and tuning completion toward the block.
	output logic      [31:0] event_in,
	output logic             tune_done
);
	int tune_lat = 3; // Tuning cycles before completion; small is prompt.
	int cnt      = 0; // Cycles spent tuning so far.
	initial event_in = 32'h00000000;
	initial tune_done = 1'b0;
	// Raise the given events for exactly one clock.
	task automatic pulse(input logic [31:0] e);
		@(posedge ref_clk);
		event_in <= e;
		@(posedge ref_clk);
		event_in <= 32'h00000000;
	endtask
	// Completion is a one-cycle pulse after tune_lat cycles of tuning.
	always @(posedge ref_clk)
	begin
		cnt <= (alignment_running && !tune_done) ? cnt + 1 : 0;
		tune_done <= alignment_running && !tune_done && (cnt + 1 == tune_lat);
	end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the event enable and tuning block.
// Assumes the card model file and the package are compiled first.
`timescale 1ns/1ps
module tb_top
	import sht_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] event_in;
	sht_auto_t   auto_status = '0;
	logic        tune_done;
	logic        cpu_irq_out;
	logic        tuned_clk_sel;
	logic        alignment_running;
	logic [2:0]  bus_speed_select;
	logic [31:0] rd;               // Last read data taken from the bus.
	int          err_total = 0;
	int          samples_checked = 0;
	always #2 ref_clk = ~ref_clk;
	sht_event_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .event_in(event_in), .auto_status(auto_status),
		.tune_done(tune_done), .cpu_irq_out(cpu_irq_out), .tuned_clk_sel(tuned_clk_sel),
		.alignment_running(alignment_running), .bus_speed_select(bus_speed_select));
	sht_card_model u_card (.ref_clk(ref_clk), .alignment_running(alignment_running),
		.event_in(event_in), .tune_done(tune_done));
	////////////////////////////////////////////////////////////////////////
	// Compare one value and count it.
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask
	// One Avalon-MM transfer, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		if (wr)
			avs_write <= 1'b1;
		else
			avs_read <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Read a register and compare it.
	task automatic rchk(input logic [2:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		chk("register", rd, exp);
	endtask
	// Let an edge land, then sample the interrupt line.
	task automatic irq_is(input logic exp);
		@(posedge ref_clk);
		#1 chk("cpu_irq_out", {31'h0, cpu_irq_out}, {31'h0, exp});
	endtask
	////////////////////////////////////////////////////////////////////////
	// Enable, control and inject read zero and the interrupt is quiet after reset.
	task automatic t_reset;
		rchk(IDX_ENABLE, ZERO_WORD);
		rchk(IDX_CTRL2, ZERO_WORD);
		rchk(IDX_INJECT, ZERO_WORD);
		chk("cpu_irq_out", {31'h0, cpu_irq_out}, 32'h0);
	endtask
	// Each event interrupts only while its own enable bit is set.
	task automatic t_gate;
		bus(1'b1, IDX_MASK, EVT_VALID);
		for (int b = 0; b < 32; b++)
			if (EVT_VALID[b])
			begin
				u_card.pulse(32'h1 << b);
				irq_is(1'b0);
				rchk(IDX_FLAGS, (32'h1 << b) | (EVT_ERRS[b] ? 32'h8000 : 32'h0));
				bus(1'b1, IDX_ENABLE, EVT_VALID & ~(32'h1 << b));
				irq_is(1'b0);
				bus(1'b1, IDX_ENABLE, 32'h1 << b);
				irq_is(1'b1);
				bus(1'b1, IDX_FLAGS, 32'h1 << b);
				irq_is(1'b0);
				bus(1'b1, IDX_ENABLE, ZERO_WORD);
			end
	endtask
	// Masked events never reach the flags.
	task automatic t_mask;
		bus(1'b1, IDX_MASK, ZERO_WORD);
		u_card.pulse(EVT_VALID);
		rchk(IDX_FLAGS, ZERO_WORD);
		bus(1'b1, IDX_MASK, EVT_VALID);
	endtask
	// Injection sets the matching flag; zero bits leave flags alone.
	task automatic t_inject;
		bus(1'b1, IDX_INJECT, ZERO_WORD);
		rchk(IDX_FLAGS, ZERO_WORD);
		for (int b = 0; b < 32; b++)
			if (EVT_VALID[b])
			begin
				bus(1'b1, IDX_INJECT, 32'h1 << b);
				rchk(IDX_INJECT, 32'h1 << b);
				rchk(IDX_FLAGS, (32'h1 << b) | (EVT_ERRS[b] ? 32'h8000 : 32'h0));
				bus(1'b1, IDX_FLAGS, 32'h1 << b);
			end
	endtask
	// Reserved bits are not stored; unmapped places read zero.
	task automatic t_resv;
		bus(1'b1, IDX_ENABLE, 32'hffffffff);
		rchk(IDX_ENABLE, EVT_VALID);
		bus(1'b1, IDX_ENABLE, ZERO_WORD);
		bus(1'b1, 3'h5, 32'hffffffff);
		rchk(3'h5, ZERO_WORD);
	endtask
	// Speed codes, tuned sampling, tuning handshake and auto-command status.
	task automatic t_ctrl2;
		for (int c = 0; c < 5; c++)
		begin
			bus(1'b1, IDX_CTRL2, 32'(c) << 16);
			rchk(IDX_CTRL2, 32'(c) << 16);
			chk("speed", {29'h0, bus_speed_select}, 32'(c));
		end
		bus(1'b1, IDX_CTRL2, 32'h00800000);
		// The select updates on the committing edge, so wait for it to settle.
		#1 chk("tuned", {31'h0, tuned_clk_sel}, 32'h1);
		u_card.tune_lat = 9;
		bus(1'b1, IDX_CTRL2, 32'h00400000);
		@(posedge ref_clk);
		#1 chk("tuning", {31'h0, alignment_running}, 32'h1);
		rchk(IDX_CTRL2, 32'h00400000);
		for (int i = 0; i < 50 && alignment_running; i++)
			@(posedge ref_clk);
		rchk(IDX_CTRL2, ZERO_WORD);
		for (int i = 0; i < 6; i++)
		begin
			auto_status <= sht_auto_t'(6'h1 << i);
			repeat (2) @(posedge ref_clk);
			rchk(IDX_CTRL2, (i == 5) ? 32'h80 : (32'h1 << i));
		end
		auto_status <= '0;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Print the counts and the verdict, then stop.
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence after two cycles of reset.
	initial
	begin
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset;
		t_gate;
		t_mask;
		t_inject;
		t_resv;
		t_ctrl2;
		test_done;
	end
	// Watchdog: the whole run needs far fewer cycles than this.
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		test_done;
	end
endmodule
